// ---- rtl/spm_pkg.sv ----
// constants, register map and types of the serial port block
// assumes a 32-bit register bus with byte addressing
package spm_pkg;
  localparam int DATA_W = 16;
  localparam int FIFO_DEPTH = 8;
  localparam int PTR_W = 3;
  localparam int CNT_W = 4;
  localparam int RATIO_W = 10;
  localparam logic [7:0] OFS_STAT = 8'h00;
  localparam logic [7:0] OFS_CON1 = 8'h04;
  localparam logic [7:0] OFS_CON2 = 8'h08;
  localparam logic [7:0] OFS_BUF = 8'h0c;
  localparam logic [15:0] REG_RST = 16'h0000;
  localparam logic [15:0] STAT_WR_MASK = 16'ha01c;
  localparam logic [15:0] CON1_WR_MASK = 16'h1fff;
  localparam logic [15:0] CON2_WR_MASK = 16'he003;
  localparam int B_EN = 15;
  localparam int B_SIDL = 13;
  localparam int B_ROV = 6;
  localparam int B_CLKDIS = 12;
  localparam int B_DODIS = 11;
  localparam int B_W16 = 10;
  localparam int B_SMP = 9;
  localparam int B_CKE = 8;
  localparam int B_SELECT_PIN_ENABLE = 7;
  localparam int B_CPOL = 6;
  localparam int B_MST = 5;
  localparam int B_FRM = 15;
  localparam int B_FSD = 14;
  localparam int B_FPOL = 13;
  localparam int B_FE = 1;
  localparam int B_ENH = 0;
  localparam logic [CNT_W-1:0] CAP_ENH = 4'h8;
  localparam logic [CNT_W-1:0] CAP_STD = 4'h1;
  localparam logic [CNT_W-1:0] RX_3Q = 4'h6;
  localparam logic [4:0] BITS16 = 5'h10;
  localparam logic [4:0] BITS8 = 5'h08;
  localparam logic [RATIO_W-1:0] RATIO_MIN = 10'h002;
  localparam logic [3:0] SEC_BASE = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SYNC = 3'b010,
    ST_SHIFT = 3'b100
  } spm_state_t;
endpackage : spm_pkg

// ---- rtl/spm_fifo_if.sv ----
// signals between the serial port core and one of its word stores
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface spm_fifo_if;
  logic flush;
  logic push;
  logic pop;
  logic [spm_pkg::DATA_W-1:0] wdata;
  logic [spm_pkg::DATA_W-1:0] rdata;
  logic [spm_pkg::CNT_W-1:0] count;
  logic [spm_pkg::CNT_W-1:0] cap;
  modport store (input flush, input push, input pop, input wdata, input cap, output rdata, output count);
  modport user (output flush, output push, output pop, output wdata, output cap, input rdata, input count);
endinterface : spm_fifo_if

// ---- rtl/spm_fifo.sv ----
// word store of up to eight entries with a movable capacity limit
// assumes push and pop come from logic on core_clk
`timescale 1ns/1ps
module spm_fifo import spm_pkg::*; (
  input wire logic core_clk,
  input wire logic rstn,
  spm_fifo_if.store f
);
  logic [DATA_W-1:0] mem [FIFO_DEPTH];
  logic [PTR_W-1:0] wp_reg, wp_next, rp_reg, rp_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic do_push, do_pop;

  always_comb begin
    do_pop = f.pop && (cnt_reg != '0);
    // a full store takes a word only when one leaves in the same cycle
    do_push = f.push && ((cnt_reg < f.cap) || do_pop);
    wp_next = wp_reg + PTR_W'(do_push);
    rp_next = rp_reg + PTR_W'(do_pop);
    cnt_next = cnt_reg + CNT_W'(do_push) - CNT_W'(do_pop);
    if (f.flush) begin
      wp_next = '0;
      rp_next = '0;
      cnt_next = '0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (do_push && !f.flush) begin
      mem[wp_reg] <= f.wdata;
    end
  end

  assign f.rdata = mem[rp_reg];
  assign f.count = cnt_reg;
endmodule : spm_fifo

// ---- rtl/spm_top.sv ----
// serial port, master or slave, with axi4-lite register access
// assumes pin inputs are asynchronous; idle_mode is on core_clk
//
// Chosen here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
// Operation
// - enable bit hands the four pins to the port; clear disables it
// - idle-stop bit freezes the port while the system is idle
// - enhanced mode count shows pending master words or unread slave words
// - shifter-empty flag is one while the shift register is free
// - word finishing while receive store is full is dropped, sticky overflow set
// - receive-empty flag is one when the receive store holds nothing
// - transmit event codes: full, store emptied, word done, slot opened
// - receive event codes: full, three quarters, data present, emptied by read
// - transmit-full flag follows the single buffer or the last free slot
// - receive-full flag follows the single buffer or the last unread slot
// - master clock pin and data-out pin can be released to general use
// - word-size bit picks sixteen or eight bit transfers
// - master samples at end of bit time if set, else in the middle
// - outside framed mode, clock-edge bit picks which clock transition changes output data
// - outside framed mode, slave uses the select pin only when select-enable is set
// - clock polarity bit sets idle level high when set, low when clear
// - master clock passes a secondary divider: 111 by one, 000 by eight
// - primary divider: 11 by one, 10 by four, 01 by sixteen, 00 by 64
// - serial clock is core clock over both ratios; one-to-one is invalid
// - framed bit enables sync on select pin; direction bit picks in or out
// - sync polarity bit and sync edge bit shape the frame pulse
// - enhanced bit routes words through stores, else single buffer
// - stores hold eight words in enhanced mode and one otherwise
// - master transfer starts as soon as a word is written
module spm_top import spm_pkg::*; (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic idle_mode,
  input wire logic shift_clock_pin_i,
  output logic shift_clock_pin_o,
  output logic shift_clock_pin_oe_n,
  output logic data_out_pin_o,
  output logic data_out_pin_oe_n,
  input wire logic data_in_pin_i,
  input wire logic select_sync_pin_i,
  output logic select_sync_pin_o,
  output logic select_sync_pin_oe_n,
  output logic buf_event
);
  function automatic logic [15:0] spm_merge(input logic [15:0] old, input logic [15:0] nw,
                                            input logic [1:0] be, input logic [15:0] msk);
    logic [15:0] m;
    m = {{8{be[1]}}, {8{be[0]}}} & msk;
    return (old & ~m) | (nw & m);
  endfunction : spm_merge

  spm_fifo_if txf();
  spm_fifo_if rxf();
  spm_fifo u_tx (.core_clk(core_clk), .rstn(rstn), .f(txf));
  spm_fifo u_rx (.core_clk(core_clk), .rstn(rstn), .f(rxf));

  logic [15:0] stat_reg, stat_next, con1_reg, con1_next, con2_reg, con2_next;
  logic rov_reg, rov_next, evt_reg, evt_next;
  logic [3:0] lv_reg, lv_next;
  logic aw_v_reg, aw_v_next, w_v_reg, w_v_next, bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [7:0] aw_a_reg, aw_a_next;
  logic [15:0] w_d_reg, w_d_next;
  logic [1:0] w_s_reg, w_s_next, bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [2:0] sync1_reg, sync2_reg, sync3_reg, filt_reg, filt_next;
  spm_state_t state_reg, state_next;
  logic [RATIO_W-1:0] div_reg, div_next, ratio, half;
  logic [15:0] txsh_reg, txsh_next, rxsh_reg, rxsh_next, rx_word, stat_view;
  logic [4:0] bit_reg, bit_next, nbits;
  logic act_reg, act_next, first_reg, first_next, sckp_reg, sckp_next;
  logic sck_reg, sck_next, sdo_reg, sdo_next, ss_reg, ss_next, fs_act;
  logic lead, trail, chg, smpl, skip, finish, tx_pop, rx_push, rx_pop, tx_push;
  logic wr_do, ar_take, tx_full, rx_full, rx_ovf, ev, sh_idle;
  logic [6:0] prim;
  logic [3:0] sec;
  logic [3:0] lv;
  logic [2:0] bec;

  logic port_enable, idle_stop, run, clock_pin_disable, dout_pin_disable, word_size_select;
  logic sample_phase, cke, select_pin_enable, clock_polarity, master_select;
  logic framed_enable, sync_direction, sync_polarity, sync_edge, enhanced_buffer_enable;
  logic [2:0] buffer_irq_select, secondary_divider;
  logic [1:0] primary_divider;
  logic sck_f, sdi_f, ss_f, lead_s, trail_s, slave_go, slave_abort;
  logic [4:0] npulse_reg, npulse_next;

  assign port_enable = stat_reg[B_EN];
  assign idle_stop = stat_reg[B_SIDL];
  assign buffer_irq_select = stat_reg[4:2];
  assign run = port_enable && !(idle_stop && idle_mode);
  assign clock_pin_disable = con1_reg[B_CLKDIS];
  assign dout_pin_disable = con1_reg[B_DODIS];
  assign word_size_select = con1_reg[B_W16];
  assign sample_phase = con1_reg[B_SMP];
  assign select_pin_enable = con1_reg[B_SELECT_PIN_ENABLE];
  assign clock_polarity = con1_reg[B_CPOL];
  assign master_select = con1_reg[B_MST];
  assign secondary_divider = con1_reg[4:2];
  assign primary_divider = con1_reg[1:0];
  assign framed_enable = con2_reg[B_FRM];
  assign sync_direction = con2_reg[B_FSD];
  assign sync_polarity = con2_reg[B_FPOL];
  assign sync_edge = con2_reg[B_FE];
  assign enhanced_buffer_enable = con2_reg[B_ENH];
  assign cke = con1_reg[B_CKE] && !framed_enable;
  assign nbits = word_size_select ? BITS16 : BITS8;
  assign sh_idle = state_reg == ST_IDLE;

  // divider ratios
  always_comb begin
    unique case (primary_divider)
      2'h3: prim = 7'h01;
      2'h2: prim = 7'h04;
      2'h1: prim = 7'h10;
      2'h0: prim = 7'h40;
    endcase
    sec = SEC_BASE - {1'b0, secondary_divider};
    ratio = {3'h0, prim} * {6'h00, sec};
    if (ratio < RATIO_MIN) begin
      ratio = RATIO_MIN;
    end
    half = {1'b0, ratio[RATIO_W-1:1]};
  end

  // pin synchronisers and filter
  always_comb begin
    filt_next = (sync2_reg & ~(sync2_reg ^ sync3_reg)) | (filt_reg & (sync2_reg ^ sync3_reg));
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
      sync3_reg <= 3'h0;
      filt_reg <= 3'h0;
    end else begin
      sync1_reg <= {select_sync_pin_i, data_in_pin_i, shift_clock_pin_i};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      filt_reg <= filt_next;
    end
  end
  assign sck_f = filt_reg[0];
  assign sdi_f = filt_reg[1];
  assign ss_f = filt_reg[2];
  assign lead_s = (sck_f != clock_polarity) && (sckp_reg == clock_polarity);
  assign trail_s = (sck_f == clock_polarity) && (sckp_reg != clock_polarity);
  assign slave_go = framed_enable ? (sync_direction && ss_f == sync_polarity) :
                    (!select_pin_enable || !ss_f);
  assign slave_abort = !framed_enable && select_pin_enable && ss_f;

  // shift engine
  always_comb begin
    state_next = state_reg;
    div_next = div_reg;
    act_next = act_reg;
    txsh_next = txsh_reg;
    rxsh_next = rxsh_reg;
    bit_next = bit_reg;
    first_next = first_reg;
    sckp_next = sck_f;
    lead = 1'b0;
    trail = 1'b0;
    chg = 1'b0;
    smpl = 1'b0;
    skip = 1'b0;
    finish = 1'b0;
    tx_pop = 1'b0;
    rx_push = 1'b0;
    if (!port_enable) begin
      state_next = ST_IDLE;
      act_next = 1'b0;
      bit_next = '0;
    end else if (run) begin
      unique case (state_reg)
        ST_IDLE: begin
          if (master_select ? (txf.count != '0) : slave_go) begin
            tx_pop = txf.count != '0;
            txsh_next = tx_pop ? txf.rdata : '0;
            div_next = '0;
            bit_next = '0;
            first_next = 1'b1;
            act_next = 1'b0;
            state_next = (master_select && framed_enable && !sync_direction && !sync_edge) ? ST_SYNC : ST_SHIFT;
          end
        end
        ST_SYNC: begin
          div_next = div_reg + 10'h001;
          if (div_reg == ratio - 10'h001) begin
            div_next = '0;
            state_next = ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (master_select) begin
            div_next = (div_reg == ratio - 10'h001) ? '0 : div_reg + 10'h001;
            lead = div_reg == '0 && bit_reg != nbits;
            trail = div_reg == half && bit_reg != nbits;
            finish = bit_reg == nbits && div_reg == ratio - 10'h001;
          end else begin
            lead = lead_s;
            trail = trail_s;
            finish = trail_s && bit_reg == nbits - 5'h01;
          end
          if (lead) begin
            act_next = 1'b1;
            first_next = 1'b0;
          end
          if (trail) begin
            act_next = 1'b0;
            bit_next = bit_reg + 5'h01;
          end
          chg = cke ? trail : lead;
          smpl = cke ? lead : trail;
          skip = first_reg && !cke && lead;
          if ((master_select && sample_phase) ? ((chg && !skip) || (finish && !cke)) : smpl) begin
            rxsh_next = {rxsh_reg[14:0], sdi_f};
          end
          if (chg && !skip) begin
            txsh_next = {txsh_reg[14:0], 1'b0};
          end
          if (finish) begin
            rx_push = 1'b1;
            state_next = ST_IDLE;
          end
          if (!master_select && slave_abort) begin
            rx_push = 1'b0;
            state_next = ST_IDLE;
            bit_next = '0;
            act_next = 1'b0;
          end
        end
        default: state_next = ST_IDLE;
      endcase
    end
    rx_word = word_size_select ? rxsh_next : {8'h00, rxsh_next[7:0]};
    sdo_next = word_size_select ? txsh_next[15] : txsh_next[7];
    sck_next = clock_polarity ^ act_next;
    fs_act = master_select && framed_enable && !sync_direction &&
             (state_next == ST_SYNC || (state_next == ST_SHIFT && sync_edge && bit_next == '0));
    ss_next = sync_polarity ? fs_act : !fs_act;
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
      div_reg <= '0;
      act_reg <= 1'b0;
      txsh_reg <= '0;
      rxsh_reg <= '0;
      bit_reg <= '0;
      first_reg <= 1'b0;
      sckp_reg <= 1'b0;
      sck_reg <= 1'b0;
      sdo_reg <= 1'b0;
      ss_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      div_reg <= div_next;
      act_reg <= act_next;
      txsh_reg <= txsh_next;
      rxsh_reg <= rxsh_next;
      bit_reg <= bit_next;
      first_reg <= first_next;
      sckp_reg <= sckp_next;
      sck_reg <= sck_next;
      sdo_reg <= sdo_next;
      ss_reg <= ss_next;
    end
  end

  // clock pulses sent in the current word, for the word length check
  always_comb begin
    npulse_next = npulse_reg;
    if (sh_idle) begin
      npulse_next = 5'h00;
    end else if (act_reg && !act_next) begin
      npulse_next = npulse_reg + 5'h01;
    end
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      npulse_reg <= 5'h00;
    end else begin
      npulse_reg <= npulse_next;
    end
  end

  // stores and flags
  assign txf.flush = !port_enable;
  assign rxf.flush = !port_enable;
  assign txf.cap = enhanced_buffer_enable ? CAP_ENH : CAP_STD;
  assign rxf.cap = txf.cap;
  assign txf.push = tx_push;
  assign txf.wdata = w_d_reg;
  assign txf.pop = tx_pop;
  assign rxf.push = rx_push;
  assign rxf.wdata = rx_word;
  assign rxf.pop = rx_pop;
  assign tx_full = txf.count >= txf.cap;
  assign rx_full = rxf.count >= rxf.cap;
  assign rx_ovf = rx_push && rx_full && !rx_pop;
  assign bec = master_select ? txf.count[2:0] : rxf.count[2:0];
  assign stat_view = {port_enable, 1'b0, idle_stop, 2'h0, bec, sh_idle, rov_reg,
                      rxf.count == '0, buffer_irq_select, tx_full, rx_full};
  assign lv = {tx_full, rx_full, rxf.count >= RX_3Q, rxf.count != '0};

  // registers, flags and buffer events
  always_comb begin
    stat_next = stat_reg;
    con1_next = con1_reg;
    con2_next = con2_reg;
    rov_next = rov_reg;
    lv_next = lv;
    if (wr_do && aw_a_reg == OFS_STAT) begin
      stat_next = spm_merge(stat_reg, w_d_reg, w_s_reg, STAT_WR_MASK);
      if (w_s_reg[0] && !w_d_reg[B_ROV]) begin
        rov_next = 1'b0;
      end
    end
    if (rx_ovf) begin
      rov_next = 1'b1;
    end
    if (wr_do && aw_a_reg == OFS_CON1) begin
      con1_next = spm_merge(con1_reg, w_d_reg, w_s_reg, CON1_WR_MASK);
    end
    if (wr_do && aw_a_reg == OFS_CON2) begin
      con2_next = spm_merge(con2_reg, w_d_reg, w_s_reg, CON2_WR_MASK);
    end
    unique case (buffer_irq_select)
      3'h7: ev = lv[3] && !lv_reg[3];
      3'h6: ev = tx_pop && txf.count == 4'h1;
      3'h5: ev = finish;
      3'h4: ev = tx_pop;
      3'h3: ev = lv[2] && !lv_reg[2];
      3'h2: ev = lv[1] && !lv_reg[1];
      3'h1: ev = lv[0] && !lv_reg[0];
      3'h0: ev = rx_pop && rxf.count == 4'h1;
    endcase
    evt_next = enhanced_buffer_enable ? ev : finish;
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      stat_reg <= REG_RST;
      con1_reg <= REG_RST;
      con2_reg <= REG_RST;
      rov_reg <= 1'b0;
      lv_reg <= 4'h0;
      evt_reg <= 1'b0;
    end else begin
      stat_reg <= stat_next;
      con1_reg <= con1_next;
      con2_reg <= con2_next;
      rov_reg <= rov_next;
      lv_reg <= lv_next;
      evt_reg <= evt_next;
    end
  end

  // axi4-lite slave
  assign awready = !aw_v_reg && !bvalid_reg;
  assign wready = !w_v_reg && !bvalid_reg;
  assign arready = !rvalid_reg;
  assign wr_do = aw_v_reg && w_v_reg;
  assign ar_take = arvalid && arready;
  assign rx_pop = ar_take && araddr == OFS_BUF;
  assign tx_push = wr_do && aw_a_reg == OFS_BUF && port_enable && w_s_reg != 2'h0;
  always_comb begin
    aw_v_next = (aw_v_reg || (awvalid && awready)) && !wr_do;
    w_v_next = (w_v_reg || (wvalid && wready)) && !wr_do;
    aw_a_next = (awvalid && awready) ? awaddr : aw_a_reg;
    w_d_next = (wvalid && wready) ? wdata[15:0] : w_d_reg;
    w_s_next = (wvalid && wready) ? wstrb[1:0] : w_s_reg;
    bvalid_next = (bvalid_reg && !bready) || wr_do;
    bresp_next = bresp_reg;
    if (wr_do) begin
      bresp_next = (aw_a_reg[7:4] == 4'h0 && aw_a_reg[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
    end
    rvalid_next = (rvalid_reg && !rready) || ar_take;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (ar_take) begin
      rresp_next = RESP_OKAY;
      unique case (araddr)
        OFS_STAT: rdata_next = {16'h0000, stat_view};
        OFS_CON1: rdata_next = {16'h0000, con1_reg};
        OFS_CON2: rdata_next = {16'h0000, con2_reg};
        OFS_BUF: rdata_next = {16'h0000, rxf.rdata};
        default: begin
          rdata_next = 32'h00000000;
          rresp_next = RESP_SLVERR;
        end
      endcase
    end
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      aw_v_reg <= 1'b0;
      w_v_reg <= 1'b0;
      aw_a_reg <= 8'h00;
      w_d_reg <= 16'h0000;
      w_s_reg <= 2'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= RESP_OKAY;
    end else begin
      aw_v_reg <= aw_v_next;
      w_v_reg <= w_v_next;
      aw_a_reg <= aw_a_next;
      w_d_reg <= w_d_next;
      w_s_reg <= w_s_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;
  assign buf_event = evt_reg;
  assign shift_clock_pin_o = sck_reg;
  assign data_out_pin_o = sdo_reg;
  assign select_sync_pin_o = ss_reg;
  assign shift_clock_pin_oe_n = !(port_enable && master_select && !clock_pin_disable);
  assign data_out_pin_oe_n = !(port_enable && !dout_pin_disable);
  assign select_sync_pin_oe_n = !(port_enable && framed_enable && !sync_direction);

  pins_off_a: assert property (@(posedge core_clk) disable iff (!rstn)
    !port_enable |-> shift_clock_pin_oe_n && data_out_pin_oe_n && select_sync_pin_oe_n)
    else $error("pins driven while port disabled");
  halt_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
    port_enable && !run && state_reg == ST_SHIFT |=> $stable(div_reg) && $stable(bit_reg))
    else $error("engine moved while halted");
  ovf_set_a: assert property (@(posedge core_clk) disable iff (!rstn)
    rx_ovf |=> rov_reg ##1 (rov_reg || ($past(wr_do) && $past(aw_a_reg) == OFS_STAT)))
    else $error("overflow flag not held");
  rxe_flag_a: assert property (@(posedge core_clk) disable iff (!rstn)
    port_enable && rx_push && rxf.count == '0 && !rx_pop |=> !stat_view[5])
    else $error("receive empty flag stuck");
  start_now_a: assert property (@(posedge core_clk) disable iff (!rstn)
    run && master_select && sh_idle && txf.count != '0 |=> !sh_idle && !stat_view[7])
    else $error("master did not start");
  txf_std_a: assert property (@(posedge core_clk) disable iff (!rstn)
    !enhanced_buffer_enable && tx_push && txf.count == '0 && !tx_pop |=> tx_full)
    else $error("transmit full not set");
  word_len_a: assert property (@(posedge core_clk) disable iff (!rstn)
    finish && master_select |-> npulse_reg == (word_size_select ? BITS16 : BITS8))
    else $error("wrong bit count at end of word");
  sck_idle_a: assert property (@(posedge core_clk) disable iff (!rstn)
    sh_idle && $past(sh_idle) && $stable(clock_polarity) |-> shift_clock_pin_o == clock_polarity)
    else $error("clock not at idle level");
  ratio_max_a: assert property (@(posedge core_clk) disable iff (!rstn)
    primary_divider == 2'h0 && secondary_divider == 3'h0 |-> ratio == 10'h200)
    else $error("divider product wrong");
  bec_view_a: assert property (@(posedge core_clk) disable iff (!rstn)
    !master_select && rx_push && !rx_pop && rxf.count < rxf.cap |=> bec == $past(bec) + 3'h1)
    else $error("element count not advanced");
endmodule : spm_top

// ---- tb/spm_peer.sv ----
// serial far end: shifts a fixed byte out, captures what arrives
// assumes clock idles low and data changes on the rising edge
`timescale 1ns/1ps
module spm_peer (
  input wire logic sck,
  input wire logic mosi,
  output logic miso,
  output logic [7:0] got
);
  logic [7:0] sh = 8'ha5;
  int n = 0;
  initial miso = 1'b0;
  always @(posedge sck) begin
    miso <= sh[7];
    sh <= {sh[6:0], sh[7]};
    n <= n + 1;
  end
  always @(negedge sck) begin
    got <= {got[6:0], mosi};
    if (n == 8) begin
      miso <= ~miso;
      n <= 0;
    end
  end
endmodule : spm_peer

// ---- tb/spm_top_tb.sv ----
// bench for the serial port: axi4-lite master, queued read checks
// assumes the far end model above on the serial pins
`timescale 1ns/1ps
module spm_top_tb;
  import spm_pkg::*;
  logic core_clk = 0, rstn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, idle = 0;
  logic [7:0] awaddr = 0, araddr = 0, got;
  logic [31:0] wdata = 0, rdata;
  logic [3:0] wstrb = 0;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, sck, sck_oe_n, sdo, sdo_oe_n, sdi, ev;
  logic [33:0] q[$];
  logic [33:0] e;
  logic [15:0] b;
  int n_fail = 0, check_count = 0;
  spm_top u_spm_top (.core_clk(core_clk), .rstn(rstn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .idle_mode(idle), .shift_clock_pin_i(1'b0), .shift_clock_pin_o(sck),
    .shift_clock_pin_oe_n(sck_oe_n), .data_out_pin_o(sdo), .data_out_pin_oe_n(sdo_oe_n),
    .data_in_pin_i(sdi), .select_sync_pin_i(1'b1), .select_sync_pin_o(), .select_sync_pin_oe_n(),
    .buf_event(ev));
  spm_peer u_spm_peer (.sck(sck), .mosi(sdo), .miso(sdi), .got(got));
  initial forever #2.5 core_clk = ~core_clk;
  task automatic chk(input logic [17:0] s, input logic [17:0] x);
    check_count++;
    if (s !== x) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, x);
    end
  endtask : chk
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  task automatic tmo;
    n_fail++;
    give_verdict();
  endtask : tmo
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    int k;
    @(posedge core_clk);
    awaddr <= a; wdata <= {16'h0000, d}; wstrb <= 4'h3; awvalid <= 1; wvalid <= 1; bready <= 1;
    for (k = 0; k < 50; k++) begin
      @(posedge core_clk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      if (bvalid) break;
    end
    bready <= 0;
    if (k == 50) tmo();
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [1:0] r, input logic [15:0] m, input logic [15:0] x);
    int k;
    @(posedge core_clk);
    q.push_back({r, m, x});
    araddr <= a; arvalid <= 1; rready <= 1;
    for (k = 0; k < 50; k++) begin
      @(posedge core_clk);
      if (arready) arvalid <= 0;
      if (rvalid) break;
    end
    rready <= 0;
    if (k == 50) tmo();
  endtask : rd
  task automatic wev;
    int k;
    for (k = 0; k < 300 && ev !== 1'b1; k++) @(posedge core_clk);
    @(posedge core_clk);
    if (k == 300) tmo();
  endtask : wev
  always @(posedge core_clk) begin
    if (rvalid && rready) begin
      e = q.pop_front();
      chk({rresp, rdata[15:0] & e[31:16]}, {e[33:32], e[15:0]});
    end
  end
  initial begin
    void'($urandom(32'h4335));
    repeat (16) @(posedge core_clk);
    rstn <= 1;
    rd(OFS_STAT, RESP_OKAY, 16'hffff, 16'h00a0);
    rd(OFS_CON1, RESP_OKAY, 16'hffff, 16'h0000);
    rd(8'h10, RESP_SLVERR, 16'hffff, 16'h0000);
    $display("reset test done");
    wr(OFS_CON1, 16'h0032);
    wr(OFS_STAT, 16'h8000);
    b = 16'($urandom_range(255));
    wr(OFS_BUF, b);
    wev();
    chk({10'h0, got}, {2'h0, b});
    chk({sck, sck_oe_n, sdo_oe_n}, 3'b000);
    rd(OFS_BUF, RESP_OKAY, 16'hffff, 16'h00a5);
    $display("transfer test done");
    wr(OFS_BUF, b);
    wr(OFS_BUF, ~b);
    wev();
    wev();
    rd(OFS_STAT, RESP_OKAY, 16'h0043, 16'h0041);
    rd(OFS_BUF, RESP_OKAY, 16'hffff, 16'h00a5);
    wr(OFS_STAT, 16'h8000);
    rd(OFS_STAT, RESP_OKAY, 16'h0041, 16'h0000);
    $display("overflow test done");
    wr(OFS_STAT, 16'ha000);
    wr(OFS_BUF, b);
    idle <= 1;
    repeat (150) @(posedge core_clk);
    rd(OFS_STAT, RESP_OKAY, 16'h0080, 16'h0000);
    idle <= 0;
    wev();
    chk({10'h0, got}, {2'h0, b});
    rd(OFS_BUF, RESP_OKAY, 16'hffff, 16'h00a5);
    $display("idle halt test done");
    wr(OFS_CON1, 16'h183b);
    chk({sck_oe_n, sdo_oe_n}, 2'b11);
    wr(OFS_STAT, 16'h0000);
    chk(sdo_oe_n, 1'b1);
    $display("release test done");
    give_verdict();
  end
endmodule : spm_top_tb
